// ---- sdl_dwell_timer.sv ----
// Phase dwell timer: one-cycle done pulse every CYC cycles.
// Assumes restart comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module sdl_dwell_timer
   import sdl_pkg::*;
#(
   parameter int unsigned CYC = PHASE_CYC
) (
   input  wire logic clk,      // Module clock
   input  wire logic srst,     // Synchronous reset
   input  wire logic restart,  // Start a fresh dwell
   output logic      done      // Dwell elapsed, one cycle
);

   typedef struct packed {
      logic [DWELL_W-1:0] cnt;
      logic               done;
   } sdl_tmr_t;

   localparam logic [DWELL_W-1:0] LAST = DWELL_W'(CYC - 1);

   sdl_tmr_t r_reg;
   sdl_tmr_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.done = 1'b0;
      if (restart) begin
         r_next.cnt = '0;
      end else if (r_reg.cnt == LAST) begin
         r_next.cnt  = '0;
         r_next.done = 1'b1;
      end else begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign done = r_reg.done;

endmodule

`default_nettype wire

// ---- sdl_panel_model.sv ----
// Operator panel model: mode switch, per-test result source, LED watcher.
// Assumes requests from the bench on the block's clock.
`timescale 1ns/100ps
`default_nettype none

module sdl_panel_model (
   input  wire logic       clk,           // Module clock
   input  wire logic [3:0] pos_req,       // Switch position wanted
   input  wire logic [4:0] fail_req,      // Tests made to fail
   input  wire logic [6:0] station_leds,  // Station LEDs seen
   output var  logic [3:0] mode_sw,       // Switch to the block
   output var  logic [4:0] test_fail,     // Results to the block
   output var  logic [7:0] n_change       // LED code changes seen
);
   logic [6:0] last_leds;

   // ----------------------------------------------------------------
   // Switch, results and change counter
   // ----------------------------------------------------------------
   initial begin
      mode_sw = 4'h0;
      test_fail = 5'h00;
      n_change = 8'h00;
      last_leds = 7'h00;
   end

   always @(posedge clk) begin
      mode_sw <= pos_req;
      test_fail <= fail_req;
      last_leds <= station_leds;
      if (station_leds != last_leds) begin
         n_change <= n_change + 8'h01;
      end
   end
endmodule

`default_nettype wire

// ---- sdl_pkg.sv ----
// Constants for the self-diagnostic LED sequencer: register map,
// field positions, LED codes and the phase dwell time.
// Assumes a 125 MHz module clock.
`default_nettype none

package sdl_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0c;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_XREQ_BIT      = 0;
   localparam int STAT_LED_LSB       = 0;
   localparam int STAT_TEST_BIT      = 7;
   localparam int STAT_FAULT_BIT     = 8;
   localparam int STAT_SELF_BIT      = 9;
   localparam int STAT_STATE_LSB     = 12;
   localparam int IRQ_ERR_BIT        = 0;
   localparam int IRQ_FAULT_BIT      = 1;
   localparam int IRQ_CYCLE_BIT      = 2;
   localparam int IRQ_W              = 3;
   localparam int LED_BIT_SIX_ERROR  = 6;
   localparam int LED_BIT_ZERO_RUNNING = 0;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

   // ----------------------------------------------------------------
   // Mode switch and LED codes
   // ----------------------------------------------------------------
   localparam logic [3:0] MODE_SELF_TEST = 4'h2;

   localparam logic [6:0] LED_OFF      = 7'h00;
   localparam logic [6:0] LED_RUN_CPU  = 7'h03;
   localparam logic [6:0] LED_RUN_TMR  = 7'h05;
   localparam logic [6:0] LED_RUN_IRQ  = 7'h07;
   localparam logic [6:0] LED_RUN_MEM1 = 7'h0b;
   localparam logic [6:0] LED_RUN_MEM2 = 7'h0d;
   localparam logic [6:0] LED_ERR_CPU  = 7'h42;
   localparam logic [6:0] LED_ERR_TMR  = 7'h44;
   localparam logic [6:0] LED_ERR_IRQ  = 7'h46;
   localparam logic [6:0] LED_ERR_MEM  = 7'h4e;

   // Test slots in test_fail
   localparam int TEST_CPU  = 0;
   localparam int TEST_TMR  = 1;
   localparam int TEST_IRQ  = 2;
   localparam int TEST_MEM1 = 3;
   localparam int TEST_MEM2 = 4;
   localparam int TEST_N    = 5;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned PHASE_TIME_NS = 100000;
   localparam int unsigned PHASE_CYC     = PHASE_TIME_NS / CLK_PERIOD_NS;
   localparam int          DWELL_W       = 16;

   // ----------------------------------------------------------------
   // Sequencer states, Gray from ST_IDLE to ST_MEM2, not on the wrap back to ST_CPU
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CPU  = 3'h1,
      ST_TMR  = 3'h3,
      ST_IRQ  = 3'h2,
      ST_MEM1 = 3'h6,
      ST_MEM2 = 3'h7,
      ST_ERR  = 3'h5
   } sdl_state_t;

endpackage

`default_nettype wire

// ---- sdl_sequencer.sv ----
// Self-diagnostic LED sequencer with fault indicator and APB registers.
// Assumes mode_sw comes from a front-panel switch (asynchronous);
// test_fail, slave_active and addr_dup come from logic on clk.
`timescale 1ns/100ps
`default_nettype none

module sdl_sequencer
   import sdl_pkg::*;
#(
   parameter int unsigned PHASE_CYCLES = PHASE_CYC
) (
   input  wire logic        clk,           // 125 MHz module clock
   input  wire logic        srst,          // Synchronous reset, high
   input  wire logic [3:0]  mode_sw,       // Rotary mode switch
   input  wire logic [4:0]  test_fail,     // Per-test failure flags
   input  wire logic        slave_active,  // An active slave was found
   input  wire logic        addr_dup,      // A slave holds the master address
   input  wire logic        psel,          // APB select
   input  wire logic        penable,       // APB enable
   input  wire logic        pwrite,        // APB direction
   input  wire logic [7:0]  paddr,         // APB byte address
   input  wire logic [31:0] pwdata,        // APB write data
   output logic [31:0]      prdata,        // APB read data
   output logic             pready,        // APB ready
   output logic             pslverr,       // APB error, unmapped address
   output logic             test_led,      // Test indicator
   output logic [6:0]       station_leds,  // Station-number LED group
   output logic             fault_led,     // Fault indicator
   output logic             irq            // Level interrupt
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      sdl_state_t       st;
      logic [6:0]       led;
      logic             test;
      logic             fault;
      logic             xreq;
      logic             xreq_d;
      logic [3:0]       m1;
      logic [3:0]       m2;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [31:0]      rdata;
   } sdl_seq_t;

   sdl_seq_t r_reg;
   sdl_seq_t r_next;

   logic selftest;
   logic tmr_done;
   logic tmr_restart;
   logic acc;
   logic wr;
   logic mapped;
   logic req_rise;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [6:0] run_code(input sdl_state_t s);
      logic [6:0] c;
      c = LED_OFF;
      unique case (s)
         ST_CPU:  c = LED_RUN_CPU;
         ST_TMR:  c = LED_RUN_TMR;
         ST_IRQ:  c = LED_RUN_IRQ;
         ST_MEM1: c = LED_RUN_MEM1;
         ST_MEM2: c = LED_RUN_MEM2;
         default: c = LED_OFF;
      endcase
      return c;
   endfunction

   function automatic logic [6:0] err_code(input sdl_state_t s);
      logic [6:0] c;
      c = LED_ERR_MEM;
      unique case (s)
         ST_CPU:  c = LED_ERR_CPU;
         ST_TMR:  c = LED_ERR_TMR;
         ST_IRQ:  c = LED_ERR_IRQ;
         default: c = LED_ERR_MEM;
      endcase
      return c;
   endfunction

   function automatic int test_slot(input sdl_state_t s);
      int i;
      i = TEST_CPU;
      unique case (s)
         ST_TMR:  i = TEST_TMR;
         ST_IRQ:  i = TEST_IRQ;
         ST_MEM1: i = TEST_MEM1;
         ST_MEM2: i = TEST_MEM2;
         default: i = TEST_CPU;
      endcase
      return i;
   endfunction

   // ----------------------------------------------------------------
   // Dwell timer
   // ----------------------------------------------------------------
   sdl_dwell_timer #(
      .CYC (PHASE_CYCLES)
   ) u_dwell (
      .clk     (clk),
      .srst    (srst),
      .restart (tmr_restart),
      .done    (tmr_done)
   );

   assign selftest    = (r_reg.m2 == MODE_SELF_TEST);
   assign tmr_restart = (r_next.st != r_reg.st);
   assign req_rise    = r_reg.xreq && !r_reg.xreq_d;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   assign acc    = psel && penable;
   assign wr     = acc && pwrite;
   assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS) ||
                   (paddr == ADDR_IRQ_STAT) || (paddr == ADDR_IRQ_MASK);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      // Switch passes two flops before use
      r_next.m1 = mode_sw;
      r_next.m2 = r_reg.m1;
      r_next.xreq_d = r_reg.xreq;

      // Register writes; W1C before events so a set wins
      if (wr && paddr == ADDR_CTRL) begin
         r_next.xreq = pwdata[CTRL_XREQ_BIT];
      end
      if (wr && paddr == ADDR_IRQ_STAT) begin
         r_next.irq_stat = r_reg.irq_stat & ~pwdata[IRQ_W-1:0];
      end
      if (wr && paddr == ADDR_IRQ_MASK) begin
         r_next.irq_mask = pwdata[IRQ_W-1:0];
      end

      // Test sequence
      unique case (r_reg.st)
         ST_IDLE: begin
            if (selftest) begin
               r_next.st = ST_CPU;
            end
         end
         ST_CPU, ST_TMR, ST_IRQ, ST_MEM1, ST_MEM2: begin
            if (tmr_done) begin
               if (test_fail[test_slot(r_reg.st)]) begin
                  r_next.st  = ST_ERR;
                  r_next.led = err_code(r_reg.st);
                  r_next.irq_stat[IRQ_ERR_BIT] = 1'b1;
               end else begin
                  unique case (r_reg.st)
                     ST_CPU:  r_next.st = ST_TMR;
                     ST_TMR:  r_next.st = ST_IRQ;
                     ST_IRQ:  r_next.st = ST_MEM1;
                     ST_MEM1: r_next.st = ST_MEM2;
                     default: begin
                        r_next.st = ST_CPU;
                        r_next.irq_stat[IRQ_CYCLE_BIT] = 1'b1;
                     end
                  endcase
               end
            end
         end
         ST_ERR: begin
            r_next.st = ST_ERR;
         end
         default: begin
            r_next.st = ST_IDLE;
         end
      endcase

      if (!selftest) begin
         r_next.st = ST_IDLE;
      end
      if (r_next.st != ST_ERR) begin
         r_next.led = run_code(r_next.st);
      end
      r_next.test = (r_next.st != ST_IDLE);

      // Fault indicator
      if (!r_reg.xreq) begin
         r_next.fault = 1'b0;
      end else if (req_rise) begin
         r_next.fault = !slave_active || addr_dup;
         if (!slave_active || addr_dup) begin
            r_next.irq_stat[IRQ_FAULT_BIT] = 1'b1;
         end
      end

      // Read data captured in the setup cycle
      if (psel && !penable) begin
         r_next.rdata = '0;
         unique case (paddr)
            ADDR_CTRL: begin
               r_next.rdata[CTRL_XREQ_BIT] = r_reg.xreq;
            end
            ADDR_STATUS: begin
               r_next.rdata[STAT_LED_LSB +: 7]   = r_reg.led;
               r_next.rdata[STAT_TEST_BIT]       = r_reg.test;
               r_next.rdata[STAT_FAULT_BIT]      = r_reg.fault;
               r_next.rdata[STAT_SELF_BIT]       = selftest;
               r_next.rdata[STAT_STATE_LSB +: 3] = r_reg.st;
            end
            ADDR_IRQ_STAT: begin
               r_next.rdata[IRQ_W-1:0] = r_reg.irq_stat;
            end
            ADDR_IRQ_MASK: begin
               r_next.rdata[IRQ_W-1:0] = r_reg.irq_mask;
            end
            default: begin
               r_next.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         r_reg          <= '0;
         r_reg.st       <= ST_IDLE;
         r_reg.irq_mask <= IRQ_MASK_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata       = r_reg.rdata;
   assign pready       = 1'b1;
   assign pslverr      = acc && !mapped;
   assign test_led     = r_reg.test;
   assign station_leds = r_reg.led;
   assign fault_led    = r_reg.fault;
   assign irq          = |(r_reg.irq_stat & r_reg.irq_mask);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_phase_pass(sdl_state_t s, int k);
      r_reg.st == s && tmr_done && !test_fail[k] && selftest;
   endsequence

   sequence s_req_rise;
      r_reg.xreq && !r_reg.xreq_d;
   endsequence

   sequence s_phase_fail(sdl_state_t s, int k);
      r_reg.st == s && tmr_done && test_fail[k] && selftest;
   endsequence

   a_mode_enter_cpu: assert property (
      (r_reg.st == ST_IDLE && selftest) |=>
      (r_reg.st == ST_CPU && station_leds == LED_RUN_CPU && test_led))
      else $error("self-test entry did not start the processor test");

   a_phase_cpu_tmr: assert property (
      s_phase_pass(ST_CPU, TEST_CPU) |=>
      (r_reg.st == ST_TMR && station_leds == LED_RUN_TMR))
      else $error("processor test not followed by timer test");

   a_phase_wrap: assert property (
      s_phase_pass(ST_MEM2, TEST_MEM2) |=>
      (r_reg.st == ST_CPU && station_leds == LED_RUN_CPU))
      else $error("second memory phase did not wrap to processor test");

   a_phase_tmr_irq: assert property (
      s_phase_pass(ST_TMR, TEST_TMR) |=>
      (r_reg.st == ST_IRQ && station_leds == LED_RUN_IRQ))
      else $error("timer test not followed by interrupt test");

   a_phase_irq_mem: assert property (
      s_phase_pass(ST_IRQ, TEST_IRQ) |=>
      (r_reg.st == ST_MEM1 && station_leds == LED_RUN_MEM1))
      else $error("interrupt test not followed by first memory phase");

   a_phase_mem_mem: assert property (
      s_phase_pass(ST_MEM1, TEST_MEM1) |=>
      (r_reg.st == ST_MEM2 && station_leds == LED_RUN_MEM2))
      else $error("first memory phase not followed by the second");

   a_error_stop_cpu: assert property (
      s_phase_fail(ST_CPU, TEST_CPU) |=>
      (r_reg.st == ST_ERR && station_leds == LED_ERR_CPU && test_led))
      else $error("processor failure did not stop on its error code");

   a_error_mem_code: assert property (
      s_phase_fail(ST_MEM2, TEST_MEM2) |=>
      (station_leds == LED_ERR_MEM && station_leds[LED_BIT_SIX_ERROR]))
      else $error("second memory phase error code wrong");

   a_error_hold: assert property (
      (r_reg.st == ST_ERR && selftest) |=>
      (r_reg.st == ST_ERR && $stable(station_leds)))
      else $error("error code not held");

   a_test_led_lit: assert property (
      selftest [*2] |-> test_led)
      else $error("test led dark in self-test");

   a_error_code: assert property (
      (r_reg.st == ST_TMR && tmr_done && test_fail[TEST_TMR] && selftest) |=>
      (station_leds == LED_ERR_TMR && station_leds[LED_BIT_SIX_ERROR]))
      else $error("timer error code wrong");

   a_run_code_flag: assert property (
      (r_reg.st != ST_IDLE && r_reg.st != ST_ERR) |->
      (!station_leds[LED_BIT_SIX_ERROR] && station_leds[LED_BIT_ZERO_RUNNING]))
      else $error("running code shows error flag");

   a_fault_no_slave: assert property (
      (s_req_rise and !slave_active) |=> fault_led)
      else $error("fault not lit with no active slave");

   a_fault_dup_addr: assert property (
      (s_req_rise and addr_dup) |=> fault_led)
      else $error("fault not lit on duplicate address");

   a_fault_dark: assert property (
      (!r_reg.xreq || (req_rise && slave_active && !addr_dup)) |=> !fault_led)
      else $error("fault lit without start-up fault");

   a_mode_exit: assert property (
      !selftest |=> (station_leds == LED_OFF && !test_led && r_reg.st == ST_IDLE))
      else $error("self-test codes not cleared on mode exit");

endmodule

`default_nettype wire

// ---- test_self_diagnostic_led_sequencer.sv ----
// Self-checking bench for the LED sequencer: self-test walk, error codes,
// fault indicator and interrupts over APB. Assumes a short phase dwell.
`timescale 1ns/100ps
`default_nettype none

module test_self_diagnostic_led_sequencer;
   import sdl_pkg::*;
   localparam int unsigned PC = 8;
   logic        clk, srst, slave_active, addr_dup, psel, penable, pwrite;
   logic        pready, pslverr, test_led, fault_led, irq, err;
   logic [7:0]  paddr, n_change, nc0;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0]  station_leds;
   logic [3:0]  mode_sw, pos_req;
   logic [4:0]  test_fail, fail_req;
   logic [15:0] rnd;
   int          n_mismatch, samples_checked, k, t;

   sdl_sequencer #(.PHASE_CYCLES(PC)) u_dut (.clk(clk), .srst(srst), .mode_sw(mode_sw),
      .test_fail(test_fail), .slave_active(slave_active), .addr_dup(addr_dup), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .test_led(test_led), .station_leds(station_leds),
      .fault_led(fault_led), .irq(irq));
   sdl_panel_model u_panel (.clk(clk), .pos_req(pos_req), .fail_req(fail_req),
      .station_leds(station_leds), .mode_sw(mode_sw), .test_fail(test_fail),
      .n_change(n_change));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [6:0] run_code(input int p);
      case (p)
         0: return 7'h03;
         1: return 7'h05;
         2: return 7'h07;
         3: return 7'h0b;
         default: return 7'h0d;
      endcase
   endfunction
   function automatic logic [6:0] err_code(input int p);
      case (p)
         0: return 7'h42;
         1: return 7'h44;
         2: return 7'h46;
         default: return 7'h4e;
      endcase
   endfunction

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         n_mismatch++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wait until masked LED bits differ from old
   task automatic wait_leds(input logic [6:0] old, input logic [6:0] m, input int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         @(posedge clk);
         #1;
         if ((station_leds & m) !== (old & m)) break;
      end
      if (i == bound) begin
         n_mismatch++;
         $display("MISMATCH led_wait expected change seen %h", station_leds);
         conclude();
      end
   endtask
   task automatic leave();
      @(posedge clk);
      pos_req <= 4'h0;
      fail_req <= 5'h00;
      // Panel flop, two sync flops, then the state update
      repeat (4) @(posedge clk);
      #1;
      chk("leds off", station_leds, 7'h00);
      chk("test off", test_led, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // Clock and main sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      {srst, slave_active, addr_dup, psel, penable, pwrite} = 6'h20;
      paddr = 8'h00;
      pwdata = 32'h0;
      pos_req = 4'h0;
      fail_req = 5'h00;
      rnd = 16'h4a82;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk("fault rst", fault_led, 1'b0);
      chk("irq rst", irq, 1'b0);
      apb(1'b0, ADDR_IRQ_MASK, 32'h0);
      chk("mask rst", rd, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      rnd = lfsr(rnd);
      @(posedge clk);
      pos_req <= (rnd[3:0] == 4'h2) ? 4'h3 : rnd[3:0];
      repeat (3 * PC) @(posedge clk);
      #1;
      chk("other pos leds", station_leds, 7'h00);
      chk("other pos test", test_led, 1'b0);
      $display("test reset done");

      @(posedge clk);
      pos_req <= 4'h2;
      wait_leds(7'h00, 7'h7f, 20);
      chk("first code", station_leds, run_code(0));
      for (k = 1; k <= 11; k++) begin
         wait_leds(station_leds, 7'h7f, 3 * PC + 10);
         chk("run code", station_leds, run_code(k % 5));
         chk("test lit", test_led, 1'b1);
      end
      $display("test pass cycle done");

      apb(1'b1, ADDR_IRQ_STAT, 32'h7);
      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      for (t = 0; t < 5; t++) begin
         leave();
         rnd = lfsr(rnd);
         @(posedge clk);
         fail_req <= (5'h01 << t) | (rnd[4:0] & ~((5'h01 << (t + 1)) - 5'h01));
         pos_req <= 4'h2;
         wait_leds(7'h00, 7'h40, 8 * PC + 40);
         chk("error code", station_leds, err_code(t));
         chk("test lit err", test_led, 1'b1);
         // Panel counts a change one edge after it shows
         repeat (2) @(posedge clk);
         nc0 = n_change;
         repeat (3 * PC) @(posedge clk);
         #1;
         chk("frozen", n_change, nc0);
         chk("held code", station_leds, err_code(t));
         apb(1'b0, ADDR_STATUS, 32'h0);
         chk("status", rd[9:0], {3'b101, err_code(t)});
         chk("irq err", irq, 1'b1);
         apb(1'b1, ADDR_IRQ_MASK, 32'h0);
         @(posedge clk);
         #1;
         chk("irq masked", irq, 1'b0);
         apb(1'b1, ADDR_IRQ_MASK, 32'h1);
         apb(1'b1, ADDR_IRQ_STAT, 32'h1);
         @(posedge clk);
         #1;
         chk("irq cleared", irq, 1'b0);
      end
      leave();
      $display("test error codes done");

      for (k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         @(posedge clk);
         slave_active <= (k < 4) ? k[0] : rnd[0];
         addr_dup <= (k < 4) ? k[1] : rnd[1];
         apb(1'b1, ADDR_CTRL, 32'h1);
         repeat (3) @(posedge clk);
         #1;
         chk("fault on start", fault_led, (!slave_active || addr_dup));
         apb(1'b1, ADDR_CTRL, 32'h0);
         repeat (3) @(posedge clk);
         #1;
         chk("fault idle", fault_led, 1'b0);
      end
      $display("test fault done");
      conclude();
   end
endmodule

`default_nettype wire
